/* hms_pkg.sv */
// Package of constants, method codes and state encoding for the homing sequencer
package hms_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned HMS_CLK_HZ      = 10_000_000;
  localparam int unsigned HMS_TIMEOUT_MS  = 20_000;
  localparam int unsigned HMS_TIMEOUT_CYC = HMS_TIMEOUT_MS * (HMS_CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Homing method codes
  // ----------------------------------------------------------------
  localparam logic [7:0] HMS_M_NEG_LIMIT  = 8'h01;
  localparam logic [7:0] HMS_M_POS_LIMIT  = 8'h02;
  localparam logic [7:0] HMS_M_HOME_A     = 8'h03;
  localparam logic [7:0] HMS_M_HOME_B     = 8'h04;
  localparam logic [7:0] HMS_M_HOME_C     = 8'h05;
  localparam logic [7:0] HMS_M_HOME_D     = 8'h06;
  localparam logic [7:0] HMS_M_LIM_HOME   = 8'h07;
  localparam logic [7:0] HMS_M_LIM_HOME_R = 8'h08;

  // ----------------------------------------------------------------
  // Control and status word bit positions
  // ----------------------------------------------------------------
  localparam int unsigned HMS_CW_START    = 4;
  localparam int unsigned HMS_SW_TARGET   = 10;
  localparam int unsigned HMS_SW_ATTAINED = 12;
  localparam int unsigned HMS_SW_ERROR    = 13;
  localparam int unsigned HMS_SW_HOMEFLAG = 15;

  // ----------------------------------------------------------------
  // Synchronised input indices
  // ----------------------------------------------------------------
  localparam int unsigned HMS_IN_NEG   = 0;
  localparam int unsigned HMS_IN_POS   = 1;
  localparam int unsigned HMS_IN_HOME  = 2;
  localparam int unsigned HMS_IN_INDEX = 3;
  localparam int unsigned HMS_IN_NUM   = 4;

  localparam logic [3:0] HMS_SYNC_RST = 4'h0;

  // ----------------------------------------------------------------
  // States, Gray coded along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HMS_IDLE  = 3'h0,
    HMS_RUN_A = 3'h1,  // waiting for rising edge of the deceleration signal
    HMS_RUN_B = 3'h3,  // waiting for falling edge
    HMS_RUN_C = 3'h2,  // waiting for home rising edge before index
    HMS_INDEX = 3'h7,  // armed, waiting for index pulse
    HMS_DONE  = 3'h6,
    HMS_ERR   = 3'h5
  } hms_state_t;

endpackage : hms_pkg

/* hms_homing_sequencer.sv */
// Homing method sequencer: direction and search-speed selection from switch and index inputs
`timescale 1ns/1ps

// Contract
// - First search speed is the high speed, second is the low speed.
// - Method 1, negative limit clear: negative fast, rise reverses slow, fall arms index.
// - Method 1, negative limit set: positive slow, fall arms index.
// - Positive-limit method, clear: positive fast, rise reverses slow, fall arms index.
// - Positive-limit method, set: negative slow, fall arms index.
// - First home method: clear positive fast then negative slow; set negative slow.
// - Second home method, clear: positive slow, index after home rise.
// - Second home method, set: negative fast, fall slows, index after rise.
// - Third home method: clear negative fast, rise reverses slow; set negative slow.
// - Fourth home method: clear negative slow; set positive fast, fall reverses slow.
// - Limit-aware method: positive fast, home rise reverses slow, fall arms index.
// - Limit-aware method: positive limit reverses fast negative, home rise slows.
// - Method 8 clear: as limit-aware, but home fall reverses positive slow, index.
// - Method 8 set: negative slow, fall reverses positive slow, index after rise.
// - Control word bit 4 starts or continues homing; no start while it is 0.
// - Status bit 13 reports timeout or excessive following deviation.
// - On completion position is preset to the home offset.
// - Commanded speed is limited to the smaller of the two maximum speeds.
module hms_homing_sequencer
  import hms_pkg::*;
#(
  parameter int unsigned SPD_W       = 32,
  parameter int unsigned POS_W       = 32,
  parameter int unsigned TIMEOUT_CYC = HMS_TIMEOUT_CYC
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic             i_negative_limit_input,
  input  wire logic             i_positive_limit_input,
  input  wire logic             i_home_switch,
  input  wire logic             i_index_pulse,
  input  wire logic [15:0]      i_control_word,
  input  wire logic [7:0]       i_homing_method,
  input  wire logic [SPD_W-1:0] i_search_speed_high,
  input  wire logic [SPD_W-1:0] i_search_speed_low,
  input  wire logic [SPD_W-1:0] i_max_profile_velocity,
  input  wire logic [SPD_W-1:0] i_max_motor_speed,
  input  wire logic [31:0]      i_home_accel,
  input  wire logic [POS_W-1:0] i_home_offset,
  input  wire logic             i_following_excess,
  output logic      [SPD_W-1:0] o_speed_cmd,
  output logic                  o_dir_negative,
  output logic      [31:0]      o_accel_cmd,
  output logic      [POS_W-1:0] o_position_preset,
  output logic                  o_position_preset_load,
  output logic                  o_homing_done,
  output logic      [15:0]      o_status_word
);

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [HMS_IN_NUM-1:0] pins;
  logic [HMS_IN_NUM-1:0] sync1_q;
  logic [HMS_IN_NUM-1:0] sync2_q;
  logic [HMS_IN_NUM-1:0] prev_q;
  logic [HMS_IN_NUM-1:0] rise;
  logic [HMS_IN_NUM-1:0] fall;

  assign pins = {i_index_pulse, i_home_switch, i_positive_limit_input, i_negative_limit_input};
  genvar g;
  generate
    for (g = 0; g < HMS_IN_NUM; g++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          sync1_q[g] <= HMS_SYNC_RST[g];
          sync2_q[g] <= HMS_SYNC_RST[g];
          prev_q[g]  <= HMS_SYNC_RST[g];
        end else if (i_ce) begin
          sync1_q[g] <= pins[g];
          sync2_q[g] <= sync1_q[g];
          prev_q[g]  <= sync2_q[g];
        end
      end
      assign rise[g] = sync2_q[g] & ~prev_q[g];
      assign fall[g] = ~sync2_q[g] & prev_q[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  hms_state_t       state_q, state_d;
  logic [7:0]       meth_q, meth_d;
  logic             dir_neg_q, dir_neg_d;
  logic             fast_q, fast_d;
  logic             act_q, act_d;
  logic             cw_prev_q, cw_prev_d;
  logic [31:0]      tmo_q, tmo_d;
  logic [31:0]      accel_q, accel_d;
  logic [POS_W-1:0] preset_q, preset_d;
  logic             load_q, load_d;
  logic [SPD_W-1:0] speed_q, speed_d;
  logic             go;
  logic             start;
  logic             running;
  logic [SPD_W-1:0] spd_limit;
  logic [SPD_W-1:0] spd_sel;
  logic             lvl_start;
  logic             sig_rise;
  logic             sig_fall;
  logic             limit_aware;
  assign go          = i_control_word[HMS_CW_START];
  assign start       = go & ~cw_prev_q;
  assign running     = (state_q == HMS_RUN_A) || (state_q == HMS_RUN_B) ||
                       (state_q == HMS_RUN_C) || (state_q == HMS_INDEX);
  assign limit_aware = (meth_q == HMS_M_LIM_HOME) || (meth_q == HMS_M_LIM_HOME_R);
  // Deceleration signal of the latched method
  always_comb begin
    case (meth_q)
      HMS_M_NEG_LIMIT: {sig_rise, sig_fall} = {rise[HMS_IN_NEG], fall[HMS_IN_NEG]};
      HMS_M_POS_LIMIT: {sig_rise, sig_fall} = {rise[HMS_IN_POS], fall[HMS_IN_POS]};
      default:         {sig_rise, sig_fall} = {rise[HMS_IN_HOME], fall[HMS_IN_HOME]};
    endcase
  end

  // Level at start is taken from the method being requested, not the latched one
  always_comb begin
    case (i_homing_method)
      HMS_M_NEG_LIMIT: lvl_start = sync2_q[HMS_IN_NEG];
      HMS_M_POS_LIMIT: lvl_start = sync2_q[HMS_IN_POS];
      default:         lvl_start = sync2_q[HMS_IN_HOME];
    endcase
  end

  // Speed selection with clamp to the lower of the two maxima
  assign spd_limit = (i_max_profile_velocity < i_max_motor_speed) ?
                     i_max_profile_velocity : i_max_motor_speed;
  assign spd_sel   = fast_q ? i_search_speed_high : i_search_speed_low;

  always_comb begin
    state_d   = state_q;
    meth_d    = meth_q;
    dir_neg_d = dir_neg_q;
    fast_d    = fast_q;
    act_d     = act_q;
    cw_prev_d = go;
    tmo_d     = tmo_q;
    accel_d   = accel_q;
    preset_d  = preset_q;
    load_d    = 1'b0;
    case (state_q)
      HMS_IDLE, HMS_DONE, HMS_ERR: begin
        if (start) begin
          meth_d  = i_homing_method;
          act_d   = lvl_start;
          accel_d = i_home_accel;
          tmo_d   = 32'h0000_0000;
          fast_d  = 1'b0;
          case (i_homing_method)
            HMS_M_NEG_LIMIT: begin
              state_d   = lvl_start ? HMS_RUN_B : HMS_RUN_A;
              dir_neg_d = ~lvl_start;
              fast_d    = ~lvl_start;
            end
            HMS_M_POS_LIMIT, HMS_M_HOME_A: begin
              state_d   = lvl_start ? HMS_RUN_B : HMS_RUN_A;
              dir_neg_d = lvl_start;
              fast_d    = ~lvl_start;
            end
            HMS_M_HOME_B: begin
              state_d   = lvl_start ? HMS_RUN_B : HMS_RUN_C;
              dir_neg_d = lvl_start;
              fast_d    = lvl_start;
            end
            HMS_M_HOME_C: begin
              state_d   = lvl_start ? HMS_RUN_B : HMS_RUN_A;
              dir_neg_d = 1'b1;
              fast_d    = ~lvl_start;
            end
            HMS_M_HOME_D: begin
              state_d   = lvl_start ? HMS_RUN_B : HMS_RUN_C;
              dir_neg_d = ~lvl_start;
              fast_d    = lvl_start;
            end
            HMS_M_LIM_HOME, HMS_M_LIM_HOME_R: begin
              state_d   = lvl_start ? HMS_RUN_B : HMS_RUN_A;
              dir_neg_d = lvl_start;
              fast_d    = ~lvl_start;
            end
            default: state_d = HMS_ERR;
          endcase
        end
      end
      HMS_RUN_A: begin
        if (go) begin
          if (sig_rise) begin
            state_d   = HMS_RUN_B;
            fast_d    = 1'b0;
            // Limit-aware methods always leave negative; the others reverse
            dir_neg_d = limit_aware ? 1'b1 : ~dir_neg_q;
          end else if (limit_aware && !dir_neg_q && rise[HMS_IN_POS]) begin
            dir_neg_d = 1'b1;
          end
        end
      end
      HMS_RUN_B: begin
        if (go && sig_fall) begin
          fast_d = 1'b0;
          case (meth_q)
            HMS_M_HOME_B, HMS_M_HOME_D: begin
              state_d   = HMS_RUN_C;
              dir_neg_d = 1'b1;
            end
            HMS_M_LIM_HOME_R: begin
              state_d   = act_q ? HMS_RUN_C : HMS_INDEX;
              dir_neg_d = 1'b0;
            end
            default: state_d = HMS_INDEX;
          endcase
        end
      end
      HMS_RUN_C: begin
        if (go && rise[HMS_IN_HOME]) begin
          state_d = HMS_INDEX;
        end
      end
      HMS_INDEX: begin
        if (go && rise[HMS_IN_INDEX]) begin
          state_d  = HMS_DONE;
          preset_d = i_home_offset;
          load_d   = 1'b1;
        end
      end
      default: state_d = HMS_IDLE;
    endcase
    // Timeout counts only while moving; a paused axis does not age
    if (running && go) begin
      tmo_d = tmo_q + 32'h0000_0001;
      if ((tmo_q >= 32'(TIMEOUT_CYC - 1)) || i_following_excess) begin
        state_d = HMS_ERR;
        load_d  = 1'b0;
      end
    end
  end

  // Speed is zero when stopped, paused, done or in error
  always_comb begin
    speed_d = '0;
    if (running && go && (state_d != HMS_DONE) && (state_d != HMS_ERR)) begin
      speed_d = (spd_sel < spd_limit) ? spd_sel : spd_limit;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q   <= HMS_IDLE;
      meth_q    <= 8'h00;
      dir_neg_q <= 1'b0;
      fast_q    <= 1'b0;
      act_q     <= 1'b0;
      cw_prev_q <= 1'b0;
      tmo_q     <= 32'h0000_0000;
      accel_q   <= 32'h0000_0000;
      preset_q  <= '0;
      load_q    <= 1'b0;
      speed_q   <= '0;
    end else if (i_ce) begin
      state_q   <= state_d;
      meth_q    <= meth_d;
      dir_neg_q <= dir_neg_d;
      fast_q    <= fast_d;
      act_q     <= act_d;
      cw_prev_q <= cw_prev_d;
      tmo_q     <= tmo_d;
      accel_q   <= accel_d;
      preset_q  <= preset_d;
      load_q    <= load_d;
      speed_q   <= speed_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    o_status_word                  = 16'h0000;
    o_status_word[HMS_SW_TARGET]   = (state_q == HMS_DONE);
    o_status_word[HMS_SW_ATTAINED] = (state_q == HMS_DONE);
    o_status_word[HMS_SW_ERROR]    = (state_q == HMS_ERR);
    o_status_word[HMS_SW_HOMEFLAG] = (state_q == HMS_DONE);
  end

  assign o_speed_cmd            = speed_q;
  assign o_dir_negative         = dir_neg_q;
  assign o_accel_cmd            = accel_q;
  assign o_position_preset      = preset_q;
  assign o_position_preset_load = load_q;
  assign o_homing_done          = (state_q == HMS_DONE);

endmodule // hms_homing_sequencer

/* hms_seq_props.sv */
// Port-level assertions for the homing sequencer
`timescale 1ns/1ps
module hms_seq_props
  import hms_pkg::*;
#(
  parameter int unsigned SPD_W = 32,
  parameter int unsigned POS_W = 32
) (
  input wire logic             i_clk,
  input wire logic             i_rst,
  input wire logic [15:0]      i_control_word,
  input wire logic [SPD_W-1:0] i_search_speed_high,
  input wire logic [SPD_W-1:0] i_search_speed_low,
  input wire logic [SPD_W-1:0] i_max_profile_velocity,
  input wire logic [SPD_W-1:0] i_max_motor_speed,
  input wire logic [POS_W-1:0] i_home_offset,
  input wire logic             i_following_excess,
  input wire logic [SPD_W-1:0] o_speed_cmd,
  input wire logic [POS_W-1:0] o_position_preset,
  input wire logic             o_position_preset_load,
  input wire logic             o_homing_done,
  input wire logic [15:0]      o_status_word
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [SPD_W-1:0] cap;
  logic [SPD_W-1:0] cap_q, hi_q, lo_q;
  assign cap = (i_max_profile_velocity < i_max_motor_speed) ?
               i_max_profile_velocity : i_max_motor_speed;
  // Speed is registered, so it is judged against last cycle's inputs
  always_ff @(posedge i_clk) begin
    cap_q <= cap;
    hi_q  <= (i_search_speed_high < cap) ? i_search_speed_high : cap;
    lo_q  <= (i_search_speed_low < cap) ? i_search_speed_low : cap;
  end
  sequence s_load_pulse;
    o_position_preset_load ##1 !o_position_preset_load;
  endsequence
  property p_speed_sel;
    o_speed_cmd != '0 |-> (o_speed_cmd == hi_q) || (o_speed_cmd == lo_q);
  endproperty
  property p_clamp;
    o_speed_cmd <= cap_q;
  endproperty
  property p_done_entry;
    $rose(o_homing_done) |-> s_load_pulse;
  endproperty
  property p_done_hold;
    o_homing_done && !(i_control_word[4] && !$past(i_control_word[4])) |=> o_homing_done;
  endproperty
  property p_done_zero;
    o_homing_done |-> o_speed_cmd == '0 && o_status_word[15:10] == 6'h25;
  endproperty
  property p_preset;
    o_position_preset_load |-> o_position_preset == $past(i_home_offset);
  endproperty
  property p_bit4_low;
    !i_control_word[HMS_CW_START] [*2] |-> o_speed_cmd == '0;
  endproperty
  property p_excess;
    i_following_excess && i_control_word[4] && o_speed_cmd != '0
      |-> ##[1:3] o_status_word[HMS_SW_ERROR];
  endproperty
  property p_err_stop;
    o_status_word[HMS_SW_ERROR] |-> o_speed_cmd == '0 && !o_homing_done;
  endproperty
  a_speed_sel: assert property (p_speed_sel) else $error("speed not a search speed");
  a_clamp: assert property (p_clamp) else $error("speed above limit");
  a_done_entry: assert property (p_done_entry) else $error("no single load");
  a_done_hold: assert property (p_done_hold) else $error("done dropped");
  a_done_zero: assert property (p_done_zero) else $error("done state wrong");
  a_preset: assert property (p_preset) else $error("preset not offset");
  a_bit4_low: assert property (p_bit4_low) else $error("moving without start");
  a_excess: assert property (p_excess) else $error("excess not flagged");
  a_err_stop: assert property (p_err_stop) else $error("moving in error");
endmodule // hms_seq_props

bind hms_homing_sequencer hms_seq_props #(.SPD_W(SPD_W), .POS_W(POS_W)) i_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_control_word(i_control_word),
  .i_search_speed_high(i_search_speed_high), .i_search_speed_low(i_search_speed_low),
  .i_max_profile_velocity(i_max_profile_velocity), .i_max_motor_speed(i_max_motor_speed),
  .i_home_offset(i_home_offset), .i_following_excess(i_following_excess),
  .o_speed_cmd(o_speed_cmd), .o_position_preset(o_position_preset),
  .o_position_preset_load(o_position_preset_load), .o_homing_done(o_homing_done),
  .o_status_word(o_status_word));

/* hms_host_model.sv */
// Host controller model driving the control word
`timescale 1ns/1ps
module hms_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  output logic      [15:0] o_control_word
);
  logic go_q;
  // Start bit only moves on an edge, so every drop lasts a whole cycle
  always_ff @(posedge i_clk) begin
    go_q <= i_go;
  end
  // Enable bits held set, only the homing start bit toggles
  assign o_control_word = {11'h000, go_q, 4'hF};
endmodule // hms_host_model

/* test_homing_sequencer.sv */
// Self-checking bench for the homing sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module test_homing_sequencer
  import hms_pkg::*;
;
  localparam int unsigned TMO = 200;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        go    = 1'b0;
  logic        exc   = 1'b0;
  logic        idx   = 1'b0;
  logic [2:0]  pins  = 3'h0;
  logic [7:0]  meth  = 8'h01;
  logic [31:0] hi = 32'h0, lo = 32'h0, mp = 32'h0, mm = 32'h0, acc = 32'h0, ofs = 32'h0;
  logic [15:0] cw, sw;
  logic [31:0] spd, acmd, pre;
  logic        dneg, load, done;
  int          err_total = 0;
  int          tests_run = 0;
  int          nload = 0;
  // Method, start pins, first leg, event count, then events of pin/level and leg
  logic [47:0] tbl [18] = '{48'h1032_1000_0000, 48'h1101_0000_0000, 48'h2012_3222_0000,
    48'h2221_2200_0000, 48'h3012_5242_0000, 48'h3421_4200_0000, 48'h4001_5000_0000,
    48'h4432_4252_0000, 48'h5032_5040_0000, 48'h5421_4200_0000, 48'h6021_5200_0000,
    48'h6412_4252_0000, 48'h7012_5242_0000, 48'h7014_3323_5242, 48'h7421_4200_0000,
    48'h8012_5240_0000, 48'h8013_3352_4000, 48'h8422_4050_0000};

  always #50 i_clk = ~i_clk;
  always @(negedge i_clk) if (load === 1'b1) nload++;

  hms_host_model i_host (.i_clk(i_clk), .i_go(go), .o_control_word(cw));
  hms_homing_sequencer #(.TIMEOUT_CYC(TMO)) i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_negative_limit_input(pins[0]),
    .i_positive_limit_input(pins[1]), .i_home_switch(pins[2]), .i_index_pulse(idx),
    .i_control_word(cw), .i_homing_method(meth), .i_search_speed_high(hi),
    .i_search_speed_low(lo), .i_max_profile_velocity(mp), .i_max_motor_speed(mm),
    .i_home_accel(acc), .i_home_offset(ofs), .i_following_excess(exc),
    .o_speed_cmd(spd), .o_dir_negative(dneg), .o_accel_cmd(acmd), .o_position_preset(pre),
    .o_position_preset_load(load), .o_homing_done(done), .o_status_word(sw));

  task automatic end_sim();
    $display("tests %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #10;
  endtask
  function automatic logic [31:0] clampv(input logic [31:0] v);
    logic [31:0] m;
    m = (mp < mm) ? mp : mm;
    return (v < m) ? v : m;
  endfunction
  task automatic leg(input logic [3:0] e);
    `CHK("direction", e[1], dneg)
    `CHK("speed", clampv(e[0] ? hi : lo), spd)
  endtask
  task automatic wait_sw(input int b, input int lim);
    int c;
    c = 0;
    while (sw[b] !== 1'b1 && c < lim) begin
      tick(1);
      c++;
    end
    if (c >= lim) begin
      err_total++;
      $display("CHECK FAILED status bit %0d exp 1 got 0", b);
      end_sim();
    end
  endtask
  task automatic start(input logic [7:0] m);
    meth = m;
    go   = 1'b0;
    tick(4);
    go = 1'b1;
    tick(8);
  endtask

  initial begin
    int k;
    logic [47:0] w;
    logic [7:0] e;
    e = 8'h00;
    void'($urandom(26331));
    tick(5);
    i_rst = 1'b0;
    for (int i = 0; i < 18; i++) begin
      w   = tbl[i];
      hi  = 32'($urandom_range(9000, 2000));
      lo  = 32'($urandom_range(1999, 1));
      mp  = 32'($urandom_range(12000, 3000));
      mm  = 32'($urandom_range(12000, 3000));
      acc = $urandom();
      ofs = $urandom();
      pins = w[42:40];
      k = nload;
      start({4'h0, w[47:44]});
      for (int j = 0; j <= int'(w[35:32]); j++) begin
        if (j > 0) begin
          e = w[39-8*j -: 8];
          pins[e[6:5]] = e[4];
          tick(8);
        end
        leg(j == 0 ? w[39:36] : e[3:0]);
      end
      `CHK("accel", acc, acmd)
      idx = 1'b1;
      tick(2);
      idx = 1'b0;
      wait_sw(HMS_SW_HOMEFLAG, 10);
      tick(1);
      `CHK("done", 1'b1, done)
      `CHK("status", 16'h9400, sw)
      `CHK("stop speed", 32'h0, spd)
      `CHK("preset", ofs, pre)
      `CHK("loads", k + 1, nload)
      go = 1'b0;
      $display("test %0d method %0d finished", i, w[47:44]);
    end
    tick(20);
    `CHK("idle speed", 32'h0, spd)
    `CHK("done held", 1'b1, done)
    pins = 3'h0;
    start(HMS_M_NEG_LIMIT);
    go = 1'b0;
    tick(6);
    `CHK("paused speed", 32'h0, spd)
    go = 1'b1;
    tick(6);
    leg(4'h3);
    wait_sw(HMS_SW_ERROR, 300);
    tick(1);
    `CHK("timeout speed", 32'h0, spd)
    $display("test pause and timeout finished");
    start(HMS_M_HOME_A);
    `CHK("error cleared", 1'b0, sw[HMS_SW_ERROR])
    exc = 1'b1;
    tick(1);
    exc = 1'b0;
    wait_sw(HMS_SW_ERROR, 5);
    for (int m = 0; m < 2; m++) begin
      start(m == 0 ? 8'h00 : 8'h09);
      `CHK("bad method", 1'b1, sw[HMS_SW_ERROR])
    end
    $display("test error cases finished");
    end_sim();
  end
endmodule // test_homing_sequencer
